// [hw/nvmc_pkg.sv]
// nvmc_pkg: shared constants and types of the nonvolatile access control block.
// assumes one core clock domain; the arrays answer every command with done or fail.
package nvmc_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h1;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h2;

   // interrupt event bit positions
   localparam int IRQ_N = 3;
   localparam int EV_DONE = 0;
   localparam int EV_ERR = 1;
   localparam int EV_READ = 2;

   // control register layout, bit 7 first
   typedef struct packed {
      logic pgm_sel;     // program_space_select
      logic cfg_sel;     // config_space_select
      logic latch_only;  // latch_only_load
      logic erase_sel;
      logic err;         // program_error_flag
      logic enable;      // program_erase_enable
      logic wr_start;
      logic rd_start;
   } nvmc_ctrl_t;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic ERR_POR = 1'h0;

   // target space and array operation codes
   typedef enum logic [1:0] {TGT_EEPROM, TGT_FLASH, TGT_CONFIG} nvmc_tgt_t;
   typedef enum logic [1:0] {OP_LATCH, OP_PROGRAM, OP_ERASE, OP_WRITE} nvmc_op_t;

   // command to the arrays and one-cycle read request
   typedef struct packed {
      logic valid;
      nvmc_tgt_t tgt;
      nvmc_op_t op;
   } nvmc_cmd_t;

   typedef struct packed {
      logic rd;
      nvmc_tgt_t tgt;
   } nvmc_rdreq_t;

endpackage

// [hw/nvmc_irq.sv]
// nvmc_irq: sticky event status, mask and one level interrupt.
// assumes events are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module nvmc_irq #(
   parameter int N = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // events and software access
   input wire logic [N-1:0] ev,
   input wire logic rd_clr,
   input wire logic mask_we,
   input wire logic [N-1:0] mask_wd,
   // state out
   output logic [N-1:0] stat,
   output logic [N-1:0] mask,
   output logic irq
);
   typedef struct packed {
      logic [N-1:0] stat;
      logic [N-1:0] mask;
   } nvmc_irq_st_t;

   nvmc_irq_st_t s;
   nvmc_irq_st_t next_s;

   // read clears, but an event in the same cycle wins
   always_comb begin
      next_s = s;
      next_s.stat = (s.stat & ~{N{rd_clr}}) | ev;
      if (mask_we) begin
         next_s.mask = mask_wd;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign stat = s.stat;
   assign mask = s.mask;
   assign irq = |(s.stat & s.mask);

   ev_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
      ev[0] |=> stat[0]) else $error("event bit not held");
endmodule
`default_nettype wire

// [hw/nvmc_seq.sv]
// nvmc_seq: issues one or two array commands per write start and waits on them.
// assumes the arrays answer each command with a done or a fail pulse.
`timescale 1ns/1ps
`default_nettype none
module nvmc_seq (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // launch
   input wire logic start,
   input wire nvmc_pkg::nvmc_tgt_t tgt,
   input wire logic erase_sel,
   input wire logic latch_only,
   // array side
   output nvmc_pkg::nvmc_cmd_t cmd,
   input wire logic arr_done,
   input wire logic arr_fail,
   // results
   output logic busy,
   output logic fin_ok,
   output logic fin_fail,
   output logic ers_done
);
   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT_A, SQ_WAIT_B} nvmc_sq_t;
   typedef struct packed {
      nvmc_sq_t state;
      nvmc_pkg::nvmc_op_t op_b;
      logic has_b;
      nvmc_pkg::nvmc_cmd_t cmd;
      logic ok;
      logic fail;
      logic ers;
   } nvmc_seq_st_t;

   nvmc_seq_st_t s;
   nvmc_seq_st_t next_s;

   // choose the command pair at launch, then step through it
   always_comb begin
      next_s = s;
      next_s.cmd.valid = 1'b0;
      next_s.ok = 1'b0;
      next_s.fail = 1'b0;
      next_s.ers = 1'b0;
      case (s.state)
         SQ_IDLE: begin
            if (start) begin
               next_s.cmd.valid = 1'b1;
               next_s.cmd.tgt = tgt;
               next_s.has_b = 1'b0;
               next_s.state = SQ_WAIT_A;
               if (tgt == nvmc_pkg::TGT_EEPROM) begin
                  next_s.cmd.op = nvmc_pkg::OP_ERASE;
                  next_s.op_b = nvmc_pkg::OP_WRITE;
                  next_s.has_b = 1'b1;
               end else if (erase_sel) begin
                  next_s.cmd.op = nvmc_pkg::OP_ERASE;
               end else if (latch_only) begin
                  next_s.cmd.op = nvmc_pkg::OP_LATCH;
               end else begin
                  next_s.cmd.op = nvmc_pkg::OP_LATCH;
                  next_s.op_b = nvmc_pkg::OP_PROGRAM;
                  next_s.has_b = 1'b1;
               end
            end
         end
         SQ_WAIT_A: begin
            if (arr_fail) begin
               next_s.fail = 1'b1;
               next_s.state = SQ_IDLE;
            end else if (arr_done && s.has_b) begin
               next_s.cmd.valid = 1'b1;
               next_s.cmd.op = s.op_b;
               next_s.state = SQ_WAIT_B;
            end else if (arr_done) begin
               next_s.ok = 1'b1;
               next_s.ers = (s.cmd.op == nvmc_pkg::OP_ERASE);
               next_s.state = SQ_IDLE;
            end
         end
         SQ_WAIT_B: begin
            if (arr_fail) begin
               next_s.fail = 1'b1;
               next_s.state = SQ_IDLE;
            end else if (arr_done) begin
               next_s.ok = 1'b1;
               next_s.state = SQ_IDLE;
            end
         end
         default: begin
            next_s.state = SQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cmd = s.cmd;
   assign busy = (s.state != SQ_IDLE);
   assign fin_ok = s.ok;
   assign fin_fail = s.fail;
   assign ers_done = s.ers;
endmodule
`default_nettype wire

// [hw/nvmc_top.sv]
// nvmc_top: control register of the nonvolatile memory access path.
// assumes the flash and eeprom arrays sit on the same core clock.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module nvmc_top (
   // clock and resets
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic POR_B,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // array side
   output nvmc_pkg::nvmc_cmd_t ARR_CMD,
   output nvmc_pkg::nvmc_rdreq_t ARR_RDREQ,
   input wire logic ARR_DONE,
   input wire logic ARR_FAIL,
   // interrupt
   output logic IRQ
);
   typedef struct packed {
      nvmc_pkg::nvmc_ctrl_t ctrl;
      logic running;
      logic [7:0] rdata;
      nvmc_pkg::nvmc_rdreq_t rdreq;
   } nvmc_top_st_t;

   nvmc_top_st_t s;
   nvmc_top_st_t next_s;
   logic err;
   logic next_err;

   nvmc_pkg::nvmc_ctrl_t w;
   nvmc_pkg::nvmc_tgt_t tgt_now;
   logic wr_ctrl;
   logic launch;
   logic improper;
   logic seq_start;
   logic busy;
   logic seq_ok;
   logic seq_fail;
   logic ers_done;
   logic [nvmc_pkg::IRQ_N-1:0] ev;
   logic [nvmc_pkg::IRQ_N-1:0] stat;
   logic [nvmc_pkg::IRQ_N-1:0] mask;

   // decode of the register port
   assign w = nvmc_pkg::nvmc_ctrl_t'(WDATA);
   assign wr_ctrl = WR && (ADDR == nvmc_pkg::OFS_CTRL);

   // target space from the two select bits
   always_comb begin
      if (s.ctrl.cfg_sel) begin
         tgt_now = nvmc_pkg::TGT_CONFIG;
      end else if (s.ctrl.pgm_sel) begin
         tgt_now = nvmc_pkg::TGT_FLASH;
      end else begin
         tgt_now = nvmc_pkg::TGT_EEPROM;
      end
   end

   // a pending write start is taken once; enable decides its fate
   assign launch = s.ctrl.wr_start && !s.running;
   assign improper = launch && !s.ctrl.enable;
   assign seq_start = launch && s.ctrl.enable;

   nvmc_seq u_seq (
      .clk(CLK),
      .rst_b(RST_B),
      .start(seq_start),
      .tgt(tgt_now),
      .erase_sel(s.ctrl.erase_sel),
      .latch_only(s.ctrl.latch_only),
      .cmd(ARR_CMD),
      .arr_done(ARR_DONE),
      .arr_fail(ARR_FAIL),
      .busy(busy),
      .fin_ok(seq_ok),
      .fin_fail(seq_fail),
      .ers_done(ers_done)
   );

   // interrupt events: finished, error, read issued
   always_comb begin
      ev = '0;
      ev[nvmc_pkg::EV_DONE] = seq_ok;
      ev[nvmc_pkg::EV_ERR] = improper || seq_fail;
      ev[nvmc_pkg::EV_READ] = s.rdreq.rd;
   end

   nvmc_irq #(
      .N(nvmc_pkg::IRQ_N)
   ) u_irq (
      .clk(CLK),
      .rst_b(RST_B),
      .ev(ev),
      .rd_clr(RD && (ADDR == nvmc_pkg::OFS_IRQ_STAT)),
      .mask_we(WR && (ADDR == nvmc_pkg::OFS_IRQ_MASK)),
      .mask_wd(WDATA[nvmc_pkg::IRQ_N-1:0]),
      .stat(stat),
      .mask(mask),
      .irq(IRQ)
   );

   // control register: hardware clears first, software sets win
   always_comb begin
      next_s = s;
      next_s.rdata = 8'h00;
      next_s.rdreq.rd = 1'b0;
      next_s.ctrl.err = 1'b0;
      // read start lives one cycle, then the fetch goes out
      if (s.ctrl.rd_start) begin
         next_s.rdreq.rd = 1'b1;
         next_s.rdreq.tgt = tgt_now;
         next_s.ctrl.rd_start = 1'b0;
      end
      if (seq_start) begin
         next_s.running = 1'b1;
      end
      // refused start drops at once, nothing reaches the arrays
      if (improper) begin
         next_s.ctrl.wr_start = 1'b0;
      end
      // start bit and running drop together, so a low start means idle
      if (seq_ok || seq_fail) begin
         next_s.ctrl.wr_start = 1'b0;
         next_s.running = 1'b0;
      end
      if (ers_done && s.ctrl.cfg_sel | s.ctrl.pgm_sel) begin
         next_s.ctrl.erase_sel = 1'b0;
      end
      if (wr_ctrl) begin
         next_s.ctrl.pgm_sel = w.pgm_sel;
         next_s.ctrl.cfg_sel = w.cfg_sel;
         next_s.ctrl.latch_only = w.latch_only;
         next_s.ctrl.enable = w.enable;
         if (w.erase_sel || !ers_done) begin
            next_s.ctrl.erase_sel = w.erase_sel;
         end
         // start bits can only be set from software
         if (w.wr_start) begin
            next_s.ctrl.wr_start = 1'b1;
         end
         // a read is refused while a write is running
         if (w.rd_start && !s.running) begin
            next_s.ctrl.rd_start = 1'b1;
         end
      end
      // read data stand only in the cycle after the strobe
      if (RD) begin
         case (ADDR)
            nvmc_pkg::OFS_CTRL: begin
               next_s.rdata = {s.ctrl[7:4], err, s.ctrl[2:0]};
            end
            nvmc_pkg::OFS_IRQ_STAT: begin
               next_s.rdata = {{(8-nvmc_pkg::IRQ_N){1'b0}}, stat};
            end
            nvmc_pkg::OFS_IRQ_MASK: begin
               next_s.rdata = {{(8-nvmc_pkg::IRQ_N){1'b0}}, mask};
            end
            default: begin
               next_s.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s <= '0;
         s.ctrl <= nvmc_pkg::CTRL_RST;
      end else begin
         s <= next_s;
      end
   end

   // error flag: set beats clean finish, which beats software
   always_comb begin
      next_err = err;
      if (improper || seq_fail) begin
         next_err = 1'b1;
      end else if (seq_ok) begin
         next_err = 1'b0;
      end else if (wr_ctrl) begin
         next_err = w.err;
      end
   end

   // only power-on or brown-out reaches the error flag, so that
   // software can still see why the last attempt failed
   always_ff @(posedge CLK or negedge POR_B) begin
      if (!POR_B) begin
         err <= nvmc_pkg::ERR_POR;
      end else begin
         err <= next_err;
      end
   end

   assign RDATA = s.rdata;
   assign ARR_RDREQ = s.rdreq;

   // checks
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   target_sel_a: assert property (
      seq_start |=> ARR_CMD.valid && ARR_CMD.tgt == $past(tgt_now))
      else $error("command went to the wrong space");

   // no second command may follow a latch-only load; window fits short latencies
   latch_only_a: assert property (
      seq_start && tgt_now != nvmc_pkg::TGT_EEPROM && !s.ctrl.erase_sel
      && s.ctrl.latch_only |=> ARR_CMD.op == nvmc_pkg::OP_LATCH
      ##1 (!ARR_CMD.valid) [*8])
      else $error("latch-only write started programming");

   prog_after_latch_a: assert property (
      ARR_CMD.valid && ARR_CMD.op == nvmc_pkg::OP_PROGRAM
      |-> $past(ARR_DONE) && $past(ARR_CMD.op) == nvmc_pkg::OP_LATCH)
      else $error("program without latch load");

   eeprom_pair_a: assert property (
      ARR_CMD.valid && ARR_CMD.tgt == nvmc_pkg::TGT_EEPROM
      |-> ARR_CMD.op == nvmc_pkg::OP_ERASE
      || ($past(ARR_DONE) && $past(ARR_CMD.op) == nvmc_pkg::OP_ERASE
      && ARR_CMD.op == nvmc_pkg::OP_WRITE))
      else $error("eeprom write not erase then write");

   erase_clear_a: assert property (
      ers_done && !wr_ctrl && tgt_now != nvmc_pkg::TGT_EEPROM
      |=> !s.ctrl.erase_sel && !s.ctrl.wr_start)
      else $error("erase select not cleared");

   // right after it is set, the flag may only leave 1 again through a software write
   err_set_a: assert property (
      (improper || seq_fail) |=> err ##1 (err || $past(wr_ctrl)))
      else $error("error flag not raised");

   // a clean finish clears the flag, software cannot override it
   err_clear_a: assert property (
      seq_ok |=> !err)
      else $error("error flag left set after clean finish");

   inhibit_a: assert property (
      improper |=> !ARR_CMD.valid && !s.ctrl.wr_start && !busy)
      else $error("program attempt while disabled");

   start_held_a: assert property (
      s.ctrl.wr_start && !improper && !seq_ok && !seq_fail
      |=> s.ctrl.wr_start)
      else $error("write start dropped early");

   idle_clear_a: assert property (
      !s.ctrl.wr_start |-> !busy && !s.running)
      else $error("operation running with start low");

   // the end of an operation drops the start bit unless software sets it again
   op_end_a: assert property (
      (seq_ok || seq_fail) |=> !busy && (!s.ctrl.wr_start || $past(wr_ctrl)))
      else $error("operation end left start bit high");

   read_once_a: assert property (
      $rose(s.ctrl.rd_start) |=> ARR_RDREQ.rd && ARR_RDREQ.tgt == $past(tgt_now))
      else $error("read not fetched in one cycle");

   // a read start written during a running write never takes hold
   rd_refused_a: assert property (
      wr_ctrl && w.rd_start && s.running |=> !s.ctrl.rd_start)
      else $error("read start accepted while busy");

   reset_ctrl_a: assert property (
      $rose(RST_B) |-> s.ctrl == nvmc_pkg::CTRL_RST)
      else $error("control not cleared by reset");

   eeprom_done_c: cover property (
      ARR_CMD.valid && ARR_CMD.op == nvmc_pkg::OP_WRITE ##[1:20] seq_ok);
   flash_erase_c: cover property (ers_done);
   read_c: cover property (ARR_RDREQ.rd);
   refused_c: cover property (improper);
   aborted_c: cover property (seq_fail);
endmodule
`default_nettype wire

// [dv/nvmc_arr_model.sv]
// nvmc_arr_model: behavioural flash and eeprom arrays behind the control block.
// assumes one command at a time; each is answered after lat cycles (lat >= 1).
`timescale 1ns/1ps
`default_nettype none
module nvmc_arr_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // knobs from the bench
   input wire logic [3:0] lat,
   input wire logic fail_en,
   // command and answer
   input wire nvmc_pkg::nvmc_cmd_t cmd,
   output logic done,
   output logic fail
);
   logic [3:0] cnt;

   // one done or fail per command, never in the valid cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 4'h0;
         done <= 1'b0;
         fail <= 1'b0;
      end else begin
         done <= 1'b0;
         fail <= 1'b0;
         if (cmd.valid) begin
            cnt <= lat;
         end else if (cnt == 4'h1) begin
            cnt <= 4'h0;
            done <= !fail_en; // fail_en models an early abort
            fail <= fail_en;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// tb_top: register-level tests of the nonvolatile control block.
// assumes the array model answers every command; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [3:0] CT = nvmc_pkg::OFS_CTRL;
   localparam logic [3:0] ST = nvmc_pkg::OFS_IRQ_STAT;
   localparam logic [3:0] MK = nvmc_pkg::OFS_IRQ_MASK;
   localparam logic [3:0] EE_ERS = {nvmc_pkg::TGT_EEPROM, nvmc_pkg::OP_ERASE};
   localparam logic [3:0] EE_WR = {nvmc_pkg::TGT_EEPROM, nvmc_pkg::OP_WRITE};
   localparam logic [3:0] FL_LAT = {nvmc_pkg::TGT_FLASH, nvmc_pkg::OP_LATCH};
   localparam logic [3:0] FL_PGM = {nvmc_pkg::TGT_FLASH, nvmc_pkg::OP_PROGRAM};
   localparam logic [3:0] CF_LAT = {nvmc_pkg::TGT_CONFIG, nvmc_pkg::OP_LATCH};
   localparam logic [3:0] CF_PGM = {nvmc_pkg::TGT_CONFIG, nvmc_pkg::OP_PROGRAM};
   localparam logic [3:0] CF_ERS = {nvmc_pkg::TGT_CONFIG, nvmc_pkg::OP_ERASE};
   localparam logic [3:0] FL_ERS = {nvmc_pkg::TGT_FLASH, nvmc_pkg::OP_ERASE};
   logic clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, wr = 1'b0, rd = 1'b0, fail_en = 1'b0;
   logic [3:0] addr = 4'h0, lat = 4'h2;
   logic [7:0] wdata = 8'h00, rdata, r;
   logic [1:0] rd_tgt;
   nvmc_pkg::nvmc_cmd_t cmd;
   nvmc_pkg::nvmc_rdreq_t rdreq;
   logic done, fail, irq;
   logic [3:0] q[$];
   int n_rdreq = 0, n_errors = 0, check_count = 0;

   nvmc_top u_dut (.CLK(clk), .RST_B(rst_b), .POR_B(por_b), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .ARR_CMD(cmd), .ARR_RDREQ(rdreq),
      .ARR_DONE(done), .ARR_FAIL(fail), .IRQ(irq));
   nvmc_arr_model u_arr (.clk(clk), .rst_b(rst_b), .lat(lat), .fail_en(fail_en),
      .cmd(cmd), .done(done), .fail(fail));

   always #25 clk = ~clk;

   // log every array command and read request seen at the edge
   always @(posedge clk) begin
      if (cmd.valid === 1'b1) q.push_back({cmd.tgt, cmd.op});
      if (rdreq.rd === 1'b1) begin
         n_rdreq++;
         rd_tgt = rdreq.tgt;
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // poll write start, bounded so a stuck op cannot hang the run
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         rreg(CT, r);
         if (r[1] === 1'b0) return;
      end
      n_errors++;
      $display("unexpected at %0t: op never ended", $time);
   endtask

   task automatic run(input logic [7:0] c, input logic [7:0] fin, input logic [3:0] e0,
                      input logic [3:0] e1, input int n);
      q.delete();
      wreg(CT, c);
      wait_idle();
      chk(r, fin);
      chk(8'(q.size()), 8'(n));
      if (n > 0) chk({4'h0, q[0]}, {4'h0, e0});
      if (n > 1) chk({4'h0, q[1]}, {4'h0, e1});
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      rreg(CT, r);
      chk(r, 8'h00);
      rreg(ST, r);
      chk(r, 8'h00);
      rreg(4'hf, r);
      chk(r, 8'h00);
      $display("reset values test over");
      run(8'h02, 8'h08, 4'h0, 4'h0, 0);
      rreg(ST, r);
      chk(r & 8'h02, 8'h02);
      run(8'h26, 8'h24, EE_ERS, EE_WR, 2);
      run(8'h86, 8'h84, FL_LAT, FL_PGM, 2);
      run(8'ha6, 8'ha4, FL_LAT, 4'h0, 1);
      run(8'hc6, 8'hc4, CF_LAT, CF_PGM, 2);
      run(8'h56, 8'h44, CF_ERS, 4'h0, 1);
      run(8'h96, 8'h84, FL_ERS, 4'h0, 1);
      $display("space and operation test over");
      // slow array: write start stays up, cannot be cleared, read start refused
      lat <= 4'hc;
      wreg(CT, 8'h86);
      rreg(CT, r);
      chk(r, 8'h86);
      wreg(CT, 8'h85);
      rreg(CT, r);
      chk(r, 8'h86);
      wait_idle();
      chk(r, 8'h84);
      lat <= 4'h2;
      wreg(CT, 8'h81);
      rreg(CT, r);
      chk(r, 8'h80);
      chk(8'(n_rdreq), 8'h01);
      chk({6'h0, rd_tgt}, {6'h0, nvmc_pkg::TGT_FLASH});
      rreg(ST, r);
      chk(r & 8'h04, 8'h04);
      $display("busy and read test over");
      wreg(MK, 8'h07);
      rreg(MK, r);
      chk(r, 8'h07);
      chk({7'h0, irq}, 8'h00);
      run(8'h26, 8'h24, EE_ERS, EE_WR, 2);
      chk({7'h0, irq}, 8'h01);
      rreg(ST, r);
      chk(r, 8'h01);
      @(posedge clk);
      #1 chk({7'h0, irq}, 8'h00);
      wreg(MK, 8'h00);
      run(8'h36, 8'h34, EE_ERS, EE_WR, 2);
      chk({7'h0, irq}, 8'h00);
      $display("interrupt test over");
      fail_en <= 1'b1;
      run(8'ha6, 8'hac, FL_LAT, 4'h0, 1);
      fail_en <= 1'b0;
      // plain reset keeps the error flag, power-on clears it
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rreg(CT, r);
      chk(r, 8'h08);
      @(posedge clk);
      rst_b <= 1'b0;
      por_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      rreg(CT, r);
      chk(r, 8'h00);
      $display("error and reset test over");
      test_done();
   end

   // watchdog: the sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
`default_nettype wire
